// *** shared/acr_pkg.sv ***
package acr_pkg;

    // ----------------------------------------
    // Bus layout
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_SETUP = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 12'h008;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // Converter figures
    // ----------------------------------------
    localparam int RESULT_W = 8;
    localparam int RESULT_STEPS = 256;
    localparam logic [3:0] CHAN_LAST_INPUT = 4'ha;
    localparam logic [3:0] CHAN_FIXED_REF = 4'hf;

    // Conversion clock select codes
    localparam logic [2:0] CLK_DIV2 = 3'h0;
    localparam logic [2:0] CLK_DIV8 = 3'h1;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_RC_A = 3'h3;
    localparam logic [2:0] CLK_DIV4 = 3'h4;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    localparam logic [2:0] CLK_RC_B = 3'h7;

    localparam logic [7:0] DIV_LEN_2 = 8'h02;
    localparam logic [7:0] DIV_LEN_4 = 8'h04;
    localparam logic [7:0] DIV_LEN_8 = 8'h08;
    localparam logic [7:0] DIV_LEN_16 = 8'h10;
    localparam logic [7:0] DIV_LEN_32 = 8'h20;
    localparam logic [7:0] DIV_LEN_64 = 8'h40;

    // Reference source field codes
    localparam logic REF_SUPPLY_HI = 1'b0;
    localparam logic [1:0] REF_CODE_EXTERNAL = 2'h2;
    localparam logic [1:0] REF_CODE_FIXED = 2'h3;

    typedef enum logic [1:0] {
        ACR_VREF_SUPPLY,
        ACR_VREF_EXTERNAL,
        ACR_VREF_FIXED
    } acr_vref_t;

    // ----------------------------------------
    // Register images
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] unused;
        logic [3:0] input_channel_select;
        logic go;
        logic converter_power_on;
    } acr_control_t;

    typedef struct packed {
        logic unused_hi;
        logic [2:0] conversion_clock_select;
        logic [1:0] unused_lo;
        logic [1:0] reference_source_select;
    } acr_setup_t;

    localparam acr_control_t CONTROL_RESET = '0;
    localparam acr_setup_t SETUP_RESET = '0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 8'h00;

endpackage

// *** verilog/acr_sar.sv ***
module acr_sar #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_hi,
    output logic busy,
    output logic done,
    output logic [WIDTH-1:0] trial,
    output logic [WIDTH-1:0] result
);

    typedef enum {ACR_SAR_IDLE, ACR_SAR_CONVERT} acr_sar_state_t;

    acr_sar_state_t state_q;
    logic [WIDTH-1:0] mask_q;
    logic [WIDTH-1:0] kept;

    if (WIDTH < 2) begin : g_bad_width
        $error("acr_sar needs at least two bits");
    end

    // Drop the trial bit when the input sits below the trial level
    assign kept = cmp_hi ? trial : (trial & ~mask_q);
    assign busy = (state_q == ACR_SAR_CONVERT);

    // ----------------------------------------
    // Bit by bit search, one bit per conversion clock
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ACR_SAR_IDLE;
            mask_q <= '0;
            trial <= '0;
            result <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                ACR_SAR_IDLE: begin
                    if (start) begin
                        state_q <= ACR_SAR_CONVERT;
                        mask_q <= {1'b1, {(WIDTH-1){1'b0}}};
                        trial <= {1'b1, {(WIDTH-1){1'b0}}};
                    end
                end
                ACR_SAR_CONVERT: begin
                    if (abort) begin
                        state_q <= ACR_SAR_IDLE;
                    end else if (tick) begin
                        if (mask_q[0]) begin
                            result <= kept;
                            done <= 1'b1;
                            state_q <= ACR_SAR_IDLE;
                        end else begin
                            trial <= kept | (mask_q >> 1);
                            mask_q <= mask_q >> 1;
                        end
                    end
                end
            endcase
        end
    end

endmodule

// *** verilog/acr_top.sv ***
module acr_top #(
    parameter int RC_DIV_LEN = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [acr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [acr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_above,
    output logic converter_power_on,
    output logic [3:0] input_channel_select,
    output logic channel_fixed_ref,
    output logic channel_reserved,
    output acr_pkg::acr_vref_t reference_source,
    output logic [acr_pkg::RESULT_W-1:0] dac_trial,
    output logic sample_connect,
    output logic hold_capacitor_discharge,
    output logic conversion_busy
);

    if (RC_DIV_LEN < 2 || RC_DIV_LEN > 255) begin : g_bad_rc
        $error("RC_DIV_LEN must be 2..255");
    end
    if ((1 << acr_pkg::RESULT_W) != acr_pkg::RESULT_STEPS) begin : g_bad_steps
        $error("width and steps disagree");
    end

    acr_pkg::acr_control_t control_q;
    acr_pkg::acr_setup_t setup_q;
    logic [acr_pkg::RESULT_W-1:0] result_q;
    logic start_q;
    logic sar_busy;
    logic sar_done;
    logic [acr_pkg::RESULT_W-1:0] sar_result;
    logic [7:0] div_len;
    logic [7:0] div_cnt_q;
    logic conv_tick;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [acr_pkg::ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;
    logic do_write;
    logic wr_mapped;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_mapped = (aw_addr_q == acr_pkg::OFF_CONTROL) || (aw_addr_q == acr_pkg::OFF_SETUP)
        || (aw_addr_q == acr_pkg::OFF_RESULT);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            w_full_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_byte_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= acr_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    acr_pkg::acr_control_t wr_control;
    acr_pkg::acr_setup_t wr_setup;
    logic wr_control_hit;

    assign wr_control = w_byte_q;
    assign wr_setup = w_byte_q;
    assign wr_control_hit = do_write && w_lane0_q && (aw_addr_q == acr_pkg::OFF_CONTROL);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            control_q <= acr_pkg::CONTROL_RESET;
            start_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_control_hit) begin
                control_q.converter_power_on <= wr_control.converter_power_on;
                control_q.input_channel_select <= wr_control.input_channel_select;
                if (!wr_control.converter_power_on || !wr_control.go) begin
                    control_q.go <= 1'b0;
                end else if (!control_q.go && !sar_busy) begin
                    control_q.go <= 1'b1;
                    start_q <= 1'b1;
                end
            end
            // Completion clears go; a set written while busy was ignored above
            if (sar_done) begin
                control_q.go <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            setup_q <= acr_pkg::SETUP_RESET;
        end else if (do_write && w_lane0_q && aw_addr_q == acr_pkg::OFF_SETUP) begin
            setup_q.conversion_clock_select <= wr_setup.conversion_clock_select;
            setup_q.reference_source_select <= wr_setup.reference_source_select;
        end
    end

    // A finished conversion outranks a software write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            result_q <= acr_pkg::RESULT_RESET;
        end else if (sar_done) begin
            result_q <= sar_result;
        end else if (do_write && w_lane0_q && aw_addr_q == acr_pkg::OFF_RESULT) begin
            result_q <= w_byte_q;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= acr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= acr_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                acr_pkg::OFF_CONTROL: s_axi_rdata <= {24'h000000, 2'h0,
                    control_q.input_channel_select, control_q.go,
                    control_q.converter_power_on};
                acr_pkg::OFF_SETUP: s_axi_rdata <= {24'h000000, 1'b0,
                    setup_q.conversion_clock_select, 2'h0,
                    setup_q.reference_source_select};
                acr_pkg::OFF_RESULT: s_axi_rdata <= {24'h000000, result_q};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= acr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Conversion clock
    // ----------------------------------------
    // The RC source is modelled as a fixed division so one clock serves all
    always_comb begin
        unique case (setup_q.conversion_clock_select)
            acr_pkg::CLK_DIV2: div_len = acr_pkg::DIV_LEN_2;
            acr_pkg::CLK_DIV8: div_len = acr_pkg::DIV_LEN_8;
            acr_pkg::CLK_DIV32: div_len = acr_pkg::DIV_LEN_32;
            acr_pkg::CLK_DIV4: div_len = acr_pkg::DIV_LEN_4;
            acr_pkg::CLK_DIV16: div_len = acr_pkg::DIV_LEN_16;
            acr_pkg::CLK_DIV64: div_len = acr_pkg::DIV_LEN_64;
            acr_pkg::CLK_RC_A, acr_pkg::CLK_RC_B: div_len = 8'(RC_DIV_LEN);
        endcase
    end

    // Divider only runs during a conversion, saving power when idle
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !sar_busy || conv_tick) begin
            div_cnt_q <= 8'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    assign conv_tick = sar_busy && (div_cnt_q >= div_len - 8'h01);

    // ----------------------------------------
    // Converter core and analog controls
    // ----------------------------------------
    acr_sar #(
        .WIDTH(acr_pkg::RESULT_W)
    ) u_sar (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(conv_tick),
        .start(start_q),
        .abort(!control_q.go || !control_q.converter_power_on),
        .cmp_hi(comparator_above),
        .busy(sar_busy),
        .done(sar_done),
        .trial(dac_trial),
        .result(sar_result)
    );

    always_comb begin
        if (setup_q.reference_source_select[1] == acr_pkg::REF_SUPPLY_HI) begin
            reference_source = acr_pkg::ACR_VREF_SUPPLY;
        end else if (setup_q.reference_source_select == acr_pkg::REF_CODE_EXTERNAL) begin
            reference_source = acr_pkg::ACR_VREF_EXTERNAL;
        end else begin
            reference_source = acr_pkg::ACR_VREF_FIXED;
        end
    end

    assign converter_power_on = control_q.converter_power_on;
    assign input_channel_select = control_q.input_channel_select;
    assign channel_fixed_ref = (control_q.input_channel_select == acr_pkg::CHAN_FIXED_REF);
    assign channel_reserved = (control_q.input_channel_select > acr_pkg::CHAN_LAST_INPUT)
        && !channel_fixed_ref;
    // Tracking between conversions is how software's acquisition wait takes effect
    assign sample_connect = control_q.converter_power_on && !sar_busy;
    assign hold_capacitor_discharge = 1'b0;
    assign conversion_busy = sar_busy;

endmodule

// *** tb/acr_top_chk.sv ***
module acr_top_chk #(
    parameter int RC_DIV_LEN = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [acr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic converter_power_on,
    input wire logic [3:0] input_channel_select,
    input wire logic channel_fixed_ref,
    input wire logic channel_reserved,
    input wire logic sample_connect,
    input wire logic hold_capacitor_discharge,
    input wire logic conversion_busy
);
    // --------------------------------
    // Helpers
    // --------------------------------
    localparam int BUSY_MAX = 600;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic rd_setup_q;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_setup_q <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_setup_q <= s_axi_araddr == acr_pkg::OFF_SETUP;
        end
    end
    // --------------------------------
    // Properties
    // --------------------------------
    AST_NO_DISCHARGE: assert property (!hold_capacitor_discharge)
        else $error("hold capacitor discharged");
    AST_OFF_IDLE: assert property (!converter_power_on [*2] |-> !conversion_busy)
        else $error("busy while unpowered");
    AST_BUSY_POWER: assert property ($rose(conversion_busy) |-> $past(converter_power_on))
        else $error("conversion began unpowered");
    AST_SAMPLE: assert property (sample_connect == (converter_power_on && !conversion_busy))
        else $error("sample switch wrong");
    AST_FIXED_CHAN: assert property (channel_fixed_ref == (input_channel_select == 4'hf))
        else $error("fixed channel flag wrong");
    AST_RSV_CHAN: assert property (channel_reserved == (input_channel_select inside {[4'hb:4'he]}))
        else $error("reserved channel flag wrong");
    AST_BUSY_SPAN: assert property ($rose(conversion_busy) |-> conversion_busy [*8] ##[1:BUSY_MAX] !conversion_busy)
        else $error("conversion span wrong");
    AST_RDATA_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte");
    AST_SETUP_GAP: assert property (s_axi_rvalid && rd_setup_q |-> s_axi_rdata[3:2] == 2'h0)
        else $error("setup gap bits set");
endmodule

// *** tb/adc_clock_ref_result_ctrl_tb.sv ***
module adc_clock_ref_result_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] cs; logic [1:0] rs; logic [7:0] vin;
        acr_pkg::acr_vref_t vr; int dv;} acr_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awa = 12'h000;
    logic [11:0] ara = 12'h000;
    logic [31:0] wd = 32'h00000000;
    logic [3:0] ws = 4'h0;
    logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0, cmp = 1'b0;
    logic awr, wr, bv, arr, rv, fref, rsv, busy;
    logic [1:0] br, rr, r;
    logic [31:0] rd, d;
    logic [3:0] chan;
    logic [7:0] trial;
    logic [7:0] vin = 8'h00;
    acr_pkg::acr_vref_t vref;
    // Acquisition wait after a channel change; arbitrary but generous
    localparam int ACQ_CYCLES = 40;
    int n_errors = 0, n_checks = 0, cyc = 0, blen = 0, b0 = 0;
    acr_row_t rows [8] = '{
        '{3'h0, 2'h0, 8'h00, acr_pkg::ACR_VREF_SUPPLY, 2},
        '{3'h1, 2'h1, 8'hff, acr_pkg::ACR_VREF_SUPPLY, 8},
        '{3'h2, 2'h2, 8'h80, acr_pkg::ACR_VREF_EXTERNAL, 32},
        '{3'h3, 2'h3, 8'h7f, acr_pkg::ACR_VREF_FIXED, 16},
        '{3'h4, 2'h0, 8'h01, acr_pkg::ACR_VREF_SUPPLY, 4},
        '{3'h5, 2'h1, 8'hfe, acr_pkg::ACR_VREF_SUPPLY, 16},
        '{3'h6, 2'h2, 8'h55, acr_pkg::ACR_VREF_EXTERNAL, 64},
        '{3'h7, 2'h3, 8'haa, acr_pkg::ACR_VREF_FIXED, 16}};

    acr_top #(.RC_DIV_LEN(16)) dut (
        .ref_clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .comparator_above(cmp),
        .converter_power_on(), .input_channel_select(chan), .channel_fixed_ref(fref),
        .channel_reserved(rsv), .reference_source(vref), .dac_trial(trial),
        .sample_connect(), .hold_capacitor_discharge(), .conversion_busy(busy)
    );

    // --------------------------------
    // Clock, comparator and watchdog
    // --------------------------------
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cmp <= vin >= trial;
        if (busy) blen <= blen + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_near(input int got, input int exp, input int tol, input string what);
        n_checks++;
        if (got > exp + tol || got < exp - tol) begin
            n_errors++;
            $display("wrong value at %0t: %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask
    // Decide at the falling edge, act just after the rising edge that takes it
    task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ha, hw, hb;
        @(posedge clk);
        awa <= a;
        wd <= v;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do begin
            @(negedge clk);
            ha = awv && awr;
            hw = wv && wr;
            hb = bv;
            r = br;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
        end while (!hb);
        brd <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        logic ha, hr;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do begin
            @(negedge clk);
            ha = arv && arr;
            hr = rv;
            d = rd;
            r = rr;
            @(posedge clk);
            if (ha) arv <= 1'b0;
        end while (!hr);
        rrd <= 1'b0;
    endtask
    // Channel first, then the acquisition wait, then the start
    task automatic convert(input logic [3:0] ch);
        b0 = blen;
        axw(acr_pkg::OFF_CONTROL, {26'h0, ch, 2'b01}, 4'h1);
        chk(r, acr_pkg::RESP_OKAY, "write resp");
        repeat (ACQ_CYCLES) @(posedge clk);
        axw(acr_pkg::OFF_CONTROL, {26'h0, ch, 2'b11}, 4'h1);
        axr(acr_pkg::OFF_CONTROL);
        chk(d[1], 1'b1, "go while busy");
        for (int k = 0; k < 300 && d[1]; k++) axr(acr_pkg::OFF_CONTROL);
        chk(d[1], 1'b0, "go cleared");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------------------------------
    // Sequence
    // --------------------------------
    initial begin
        logic [3:0] ch;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            vin = rows[i].vin;
            ch = 4'(2 * i);
            axw(acr_pkg::OFF_SETUP, {25'h0, rows[i].cs, 2'b11, rows[i].rs}, 4'h1);
            chk(vref, rows[i].vr, "reference");
            axr(acr_pkg::OFF_SETUP);
            chk(d, {25'h0, rows[i].cs, 2'b00, rows[i].rs}, "setup");
            convert(ch);
            chk({rsv, fref, chan}, {ch > 4'ha && ch < 4'hf, ch == 4'hf, ch}, "chan");
            axr(acr_pkg::OFF_RESULT);
            chk(d, {24'h0, rows[i].vin}, "result");
            // Eight bit decisions, one per conversion clock period
            chk_near(blen - b0, 8 * rows[i].dv, 0, "span");
            $display("row %0d done", i);
        end
        axw(acr_pkg::OFF_RESULT, 32'h0000005a, 4'h1);
        axr(acr_pkg::OFF_RESULT);
        chk(d, 32'h0000005a, "result write");
        chk(r, acr_pkg::RESP_OKAY, "read resp");
        axw(acr_pkg::OFF_CONTROL, 32'h00000002, 4'h1);
        axr(acr_pkg::OFF_CONTROL);
        chk(d, 32'h00000000, "go unpowered");
        // Dropping power mid conversion must leave the old result
        vin = 8'hc3;
        axw(acr_pkg::OFF_SETUP, 32'h00000070, 4'h1);
        axw(acr_pkg::OFF_CONTROL, 32'h0000003d, 4'h1);
        repeat (ACQ_CYCLES) @(posedge clk);
        axw(acr_pkg::OFF_CONTROL, 32'h0000003f, 4'h1);
        chk({rsv, fref}, 2'b01, "fixed chan");
        repeat (20) @(posedge clk);
        axw(acr_pkg::OFF_CONTROL, 32'h00000000, 4'h1);
        repeat (4) @(posedge clk);
        chk(busy, 1'b0, "abort");
        axr(acr_pkg::OFF_RESULT);
        chk(d, 32'h0000005a, "aborted result");
        $display("abort test done");
        axr(12'h00c);
        chk(r, acr_pkg::RESP_SLVERR, "unmapped read");
        axw(12'h00c, 32'h000000ff, 4'h1);
        chk(r, acr_pkg::RESP_SLVERR, "unmapped write");
        axw(acr_pkg::OFF_SETUP, 32'h00000073, 4'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        axr(acr_pkg::OFF_CONTROL);
        chk(d, 32'h00000000, "control reset");
        axr(acr_pkg::OFF_SETUP);
        chk(d, 32'h00000000, "setup reset");
        $display("reset test done");
        end_sim();
    end
endmodule

bind acr_top acr_top_chk #(.RC_DIV_LEN(RC_DIV_LEN)) u_chk (
    .ref_clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .converter_power_on, .input_channel_select, .channel_fixed_ref,
    .channel_reserved, .sample_connect, .hold_capacitor_discharge, .conversion_busy
);
